// File: pkg/btac_regs.vh
`ifndef BTAC_REGS_VH
`define BTAC_REGS_VH

// Operation codes presented by the sequencer on op_i.
`define BTAC_OP_W          3
`define BTAC_OP_DEC2BIN    3'h0
`define BTAC_OP_BIN2DEC    3'h1
`define BTAC_OP_DUR2SEC    3'h2
`define BTAC_OP_SEC2DUR    3'h3
`define BTAC_OP_ASC2NIB    3'h4

// One-hot states of the sequencing machine.
`define BTAC_ST_IDLE       4'h1
`define BTAC_ST_HOUR       4'h2
`define BTAC_ST_MIN        4'h4
`define BTAC_ST_PACK       4'h8

// Numeric limits.
`define BTAC_BIN2DEC_MAX   16'h270f
`define BTAC_SEC_MAX       26'h22550ff
`define BTAC_SEC_PER_HOUR  26'h0000e10
`define BTAC_SEC_PER_MIN   26'h000003c
`define BTAC_MINSEC_MAX    8'h59

// Field positions of the position specification word.
`define BTAC_SEL_DIG_LSB   0
`define BTAC_SEL_CNT_LSB   4
`define BTAC_SEL_HALF_BIT  8
`define BTAC_SEL_PAR_LSB   12

// Parity modes of the position specification word.
`define BTAC_PAR_NONE      2'h0
`define BTAC_PAR_EVEN      2'h1
`define BTAC_PAR_ODD       2'h2

// ASCII code ranges of hexadecimal characters.
`define BTAC_ASC_0         7'h30
`define BTAC_ASC_9         7'h39
`define BTAC_ASC_A         7'h41
`define BTAC_ASC_F         7'h46

`endif

// File: src/btac_bin2bcd.v
`timescale 1ns/1ps

// Combinational shift-and-add-three binary to packed decimal converter.
module btac_bin2bcd #(
   parameter BIN_W  = 16,
   parameter DIGITS = 4
) (
   input  wire [BIN_W-1:0]    bin_i,
   output wire [4*DIGITS-1:0] bcd_o
);

   reg [BIN_W+4*DIGITS-1:0] sh;
   integer                  i;
   integer                  j;

   always @* begin
      sh = {(BIN_W+4*DIGITS){1'b0}};
      sh[BIN_W-1:0] = bin_i;
      for (i = 0; i < BIN_W; i = i + 1) begin
         for (j = 0; j < DIGITS; j = j + 1) begin
            if (sh[BIN_W+4*j +: 4] >= 4'h5) begin
               sh[BIN_W+4*j +: 4] = sh[BIN_W+4*j +: 4] + 4'h3;
            end
         end
         sh = sh << 1;
      end
   end

   assign bcd_o = sh[BIN_W +: 4*DIGITS];

endmodule // btac_bin2bcd

// File: src/btac_convert_unit.v
// What this block does
// RQ1: Only result words are written; the unit has no path back to source words.
// RQ2: Decimal-to-binary faults when any source nibble is not a decimal digit.
// RQ3: Decimal-to-binary sets zero flag when result is zero, clears otherwise.
// RQ4: Decimal-to-binary turns four packed digits into the equal 16-bit binary value.
// RQ5: Binary-to-decimal writes the equal four-digit packed decimal to the result word.
// RQ6: Binary source above 270F faults, skips execution and leaves result unchanged.
// RQ7: Binary-to-decimal sets zero flag when the result word is zero.
// RQ8: Duration input: seconds low byte, minutes high byte, hours in next word.
// RQ9: Duration-to-seconds writes eight packed digits over two result words, at most 35999999.
// RQ10: Duration-to-seconds faults on area span, non-decimal source, or minutes/seconds over 59.
// RQ11: Both time conversions set zero flag when their result is zero.
// RQ12: Seconds-to-duration faults on non-decimal, over 35999999, or area span.
// RQ13: Duration output: seconds low byte, minutes high byte, hours in next word.
// RQ14: Program must lengthen the watchdog to 180 ms for inputs above 15000000.
// RQ15: ASCII-to-nibble acts only on the condition; converts codes into destination digits.
// RQ16: Up to four codes from three source words, chosen by the selector word.
// RQ17: Destination digits wrap back to digit 0 past digit 3.
// RQ18: Program supplies hex ASCII codes and keeps source words in one area.
// RQ19: Every operation faults on a bad indirect pointer.
// RQ20: ASCII-to-nibble checks top-bit parity; mismatch faults and skips execution.
// RQ21: ASCII-to-nibble faults on codes that are not hexadecimal characters.
`timescale 1ns/1ps
`include "btac_regs.vh"

module btac_convert_unit (
   input  wire                   clk_i,
   input  wire                   rst_i,
   input  wire                   start_i,
   input  wire [`BTAC_OP_W-1:0]  op_i,
   input  wire [15:0]            src0_i,
   input  wire [15:0]            src1_i,
   input  wire [15:0]            src2_i,
   input  wire [15:0]            position_spec_word_i,
   input  wire [15:0]            dst0_i,
   input  wire                   src_span_err_i,
   input  wire                   dst_span_err_i,
   input  wire                   ptr_err_i,
   output reg                    busy_o,
   output reg                    done_o,
   output reg  [15:0]            res0_o,
   output reg  [15:0]            res1_o,
   output reg                    wr0_o,
   output reg                    wr1_o,
   output reg                    fault_flag_o,
   output reg                    zero_flag_o
);

   reg  [3:0]  state_r;
   reg  [25:0] rem_r;
   reg  [15:0] hrs_r;
   reg  [7:0]  min_r;

   wire        go = start_i && (state_r == `BTAC_ST_IDLE);

   function [15:0] dec4;
      input [15:0] w;
      begin
         dec4 = {12'h000, w[15:12]} * 16'd1000 + {12'h000, w[11:8]} * 16'd100
              + {12'h000, w[7:4]} * 16'd10 + {12'h000, w[3:0]};
      end
   endfunction

   function [7:0] dec2;
      input [7:0] b;
      begin
         dec2 = {4'h0, b[7:4]} * 8'd10 + {4'h0, b[3:0]};
      end
   endfunction

   // RQ2: Nibble digit check.
   wire [3:0] s0_dig_ok;
   wire [3:0] s1_dig_ok;
   genvar     n;
   generate
      for (n = 0; n < 4; n = n + 1) begin : g_digit
         assign s0_dig_ok[n] = (src0_i[4*n +: 4] <= 4'h9);
         assign s1_dig_ok[n] = (src1_i[4*n +: 4] <= 4'h9);
      end
   endgenerate
   wire s0_bcd = &s0_dig_ok;
   wire s1_bcd = &s1_dig_ok;

   // RQ4: Packed decimal to binary.
   wire [15:0] d2b_val = dec4(src0_i);

   // RQ8: Duration fields.
   wire [25:0] hts_total = {10'h000, dec4(src1_i)} * `BTAC_SEC_PER_HOUR
                         + {18'h00000, dec2(src0_i[15:8])} * `BTAC_SEC_PER_MIN
                         + {18'h00000, dec2(src0_i[7:0])};
   // RQ10: Duration format check.
   wire hts_bad = !s0_bcd || !s1_bcd || (src0_i[15:8] > `BTAC_MINSEC_MAX)
                || (src0_i[7:0] > `BTAC_MINSEC_MAX) || src_span_err_i || dst_span_err_i;

   // RQ12: Seconds source value.
   wire [26:0] sth_total = {11'h000, dec4(src1_i)} * 27'd10000
                         + {11'h000, dec4(src0_i)};
   // RQ12: Seconds input check.
   wire sth_bad = !s0_bcd || !s1_bcd || (sth_total > `BTAC_SEC_MAX)
                || src_span_err_i || dst_span_err_i;

   // Shared converters.
   wire [15:0] a_bin = (state_r == `BTAC_ST_PACK) ? hrs_r : src0_i;
   wire [15:0] a_bcd;
   wire [31:0] tot_bcd;
   wire [11:0] min_bcd;
   wire [11:0] sec_bcd;

   btac_bin2bcd #(.BIN_W(16), .DIGITS(4)) u_b2d_word (
      .bin_i (a_bin),
      .bcd_o (a_bcd)
   );

   // RQ9: Total seconds digits.
   btac_bin2bcd #(.BIN_W(26), .DIGITS(8)) u_b2d_total (
      .bin_i (hts_total),
      .bcd_o (tot_bcd)
   );

   // RQ13: Minute digits.
   btac_bin2bcd #(.BIN_W(8), .DIGITS(3)) u_b2d_min (
      .bin_i (min_r),
      .bcd_o (min_bcd)
   );

   btac_bin2bcd #(.BIN_W(8), .DIGITS(3)) u_b2d_sec (
      .bin_i (rem_r[7:0]),
      .bcd_o (sec_bcd)
   );

   // RQ16: Selector fields.
   wire [1:0]  hx_start = position_spec_word_i[`BTAC_SEL_DIG_LSB +: 2];
   wire [1:0]  hx_cnt   = position_spec_word_i[`BTAC_SEL_CNT_LSB +: 2];
   wire        hx_half  = position_spec_word_i[`BTAC_SEL_HALF_BIT];
   wire [1:0]  hx_par   = position_spec_word_i[`BTAC_SEL_PAR_LSB +: 2];
   wire [47:0] hx_bytes = {src2_i, src1_i, src0_i};
   wire [15:0] hx_nib;
   wire [3:0]  hx_used;
   wire [3:0]  hx_bad;

   generate
      for (n = 0; n < 4; n = n + 1) begin : g_code
         localparam [2:0] code_ix = n;
         wire [2:0] idx  = {2'b00, hx_half} + code_ix;
         wire [7:0] code = hx_bytes[{idx, 3'b000} +: 8];
         wire       dig  = (code[6:0] >= `BTAC_ASC_0) && (code[6:0] <= `BTAC_ASC_9);
         wire       alpha = (code[6:0] >= `BTAC_ASC_A) && (code[6:0] <= `BTAC_ASC_F);
         // RQ20: Parity check.
         wire       par  = (hx_par == `BTAC_PAR_NONE) ? !code[7] :
                           (hx_par == `BTAC_PAR_EVEN) ? ~^code :
                           (hx_par == `BTAC_PAR_ODD)  ? ^code : 1'b0;
         assign hx_used[n]      = (code_ix[1:0] <= hx_cnt);
         // RQ21: Hex character check.
         assign hx_bad[n]       = hx_used[n] && !(par && (dig || alpha));
         assign hx_nib[4*n +: 4] = dig ? code[3:0] : code[3:0] + 4'h9;
      end
   endgenerate

   // RQ17: Wrapping digit placement.
   reg [15:0] hx_word;
   reg [1:0]  pos;
   integer    k;
   always @* begin
      hx_word = dst0_i;
      pos = hx_start;
      for (k = 0; k < 4; k = k + 1) begin
         if (hx_used[k]) begin
            hx_word[{pos, 2'b00} +: 4] = hx_nib[4*k +: 4];
         end
         // RQ17: Wrap past digit 3.
         pos = pos + 2'b01;
      end
   end

   // RQ1: Result words only.
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r      <= `BTAC_ST_IDLE;
         rem_r        <= 26'h0000000;
         hrs_r        <= 16'h0000;
         min_r        <= 8'h00;
         busy_o       <= 1'b0;
         done_o       <= 1'b0;
         res0_o       <= 16'h0000;
         res1_o       <= 16'h0000;
         wr0_o        <= 1'b0;
         wr1_o        <= 1'b0;
         fault_flag_o <= 1'b0;
         zero_flag_o  <= 1'b0;
      end else begin
         done_o <= 1'b0;
         wr0_o  <= 1'b0;
         wr1_o  <= 1'b0;
         case (state_r)
            `BTAC_ST_IDLE: begin
               // RQ15: Act only on the condition.
               if (go) begin
                  done_o <= 1'b1;
                  // RQ19: Bad pointer faults everything.
                  if (ptr_err_i) begin
                     fault_flag_o <= 1'b1;
                  end else begin
                     case (op_i)
                        `BTAC_OP_DEC2BIN: begin
                           // RQ2: Fault on non-decimal source.
                           fault_flag_o <= !s0_bcd;
                           if (s0_bcd) begin
                              res0_o      <= d2b_val;
                              wr0_o       <= 1'b1;
                              // RQ3: Zero flag.
                              zero_flag_o <= (d2b_val == 16'h0000);
                           end
                        end
                        `BTAC_OP_BIN2DEC: begin
                           // RQ6: Range limit.
                           fault_flag_o <= (src0_i > `BTAC_BIN2DEC_MAX);
                           if (src0_i <= `BTAC_BIN2DEC_MAX) begin
                              // RQ5: Packed decimal result.
                              res0_o      <= a_bcd;
                              wr0_o       <= 1'b1;
                              // RQ7: Zero flag.
                              zero_flag_o <= (a_bcd == 16'h0000);
                           end
                        end
                        `BTAC_OP_DUR2SEC: begin
                           fault_flag_o <= hts_bad;
                           if (!hts_bad) begin
                              // RQ9: Eight digits over two words.
                              res0_o      <= tot_bcd[15:0];
                              res1_o      <= tot_bcd[31:16];
                              wr0_o       <= 1'b1;
                              wr1_o       <= 1'b1;
                              // RQ11: Zero flag.
                              zero_flag_o <= (hts_total == 26'h0000000);
                           end
                        end
                        `BTAC_OP_SEC2DUR: begin
                           if (sth_bad) begin
                              fault_flag_o <= 1'b1;
                           end else begin
                              done_o  <= 1'b0;
                              busy_o  <= 1'b1;
                              rem_r   <= sth_total[25:0];
                              hrs_r   <= 16'h0000;
                              min_r   <= 8'h00;
                              state_r <= `BTAC_ST_HOUR;
                           end
                        end
                        `BTAC_OP_ASC2NIB: begin
                           // RQ20: Mismatch skips execution.
                           fault_flag_o <= (|hx_bad) || src_span_err_i;
                           if (!(|hx_bad) && !src_span_err_i) begin
                              res0_o <= hx_word;
                              wr0_o  <= 1'b1;
                           end
                        end
                        default: begin
                           fault_flag_o <= 1'b1;
                        end
                     endcase
                  end
               end
            end
            // RQ13: Hours counted out.
            `BTAC_ST_HOUR: begin
               if (rem_r >= `BTAC_SEC_PER_HOUR) begin
                  rem_r <= rem_r - `BTAC_SEC_PER_HOUR;
                  hrs_r <= hrs_r + 16'h0001;
               end else begin
                  state_r <= `BTAC_ST_MIN;
               end
            end
            `BTAC_ST_MIN: begin
               if (rem_r >= `BTAC_SEC_PER_MIN) begin
                  rem_r <= rem_r - `BTAC_SEC_PER_MIN;
                  min_r <= min_r + 8'h01;
               end else begin
                  state_r <= `BTAC_ST_PACK;
               end
            end
            `BTAC_ST_PACK: begin
               // RQ13: Duration layout.
               res0_o       <= {min_bcd[7:0], sec_bcd[7:0]};
               res1_o       <= a_bcd;
               wr0_o        <= 1'b1;
               wr1_o        <= 1'b1;
               fault_flag_o <= 1'b0;
               // RQ11: Zero flag.
               zero_flag_o  <= (hrs_r == 16'h0000) && (min_r == 8'h00) && (rem_r == 26'h0000000);
               done_o       <= 1'b1;
               busy_o       <= 1'b0;
               state_r      <= `BTAC_ST_IDLE;
            end
            default: begin
               state_r <= `BTAC_ST_IDLE;
               busy_o  <= 1'b0;
            end
         endcase
      end
   end

endmodule // btac_convert_unit

// File: tb/btac_convert_checker.sv
`timescale 1ns/1ps
module btac_convert_checker (
   input wire        clk_i,
   input wire        rst_i,
   input wire        start_i,
   input wire        busy_o,
   input wire        done_o,
   input wire        wr0_o,
   input wire        wr1_o,
   input wire        fault_flag_o,
   input wire        zero_flag_o,
   input wire        ptr_err_i,
   input wire [2:0]  op_i,
   input wire [15:0] src0_i,
   input wire [15:0] res0_o
);
   wire take = start_i && !busy_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_single_cycle_done: assert property (take && op_i != 3'h3 |=> done_o)
      else $error("done missing one cycle after start");
   a_fault_no_write: assert property (done_o && fault_flag_o |-> !wr0_o && !wr1_o)
      else $error("write pulse on a fault");
   a_fault_keeps_result: assert property (done_o && fault_flag_o |-> $stable(res0_o))
      else $error("result changed on a fault");
   a_bin_range_fault: assert property (take && op_i == 3'h1 && src0_i > 16'h270f |=> fault_flag_o)
      else $error("binary source above limit not refused");
   a_pointer_fault: assert property (take && ptr_err_i |=> done_o && fault_flag_o)
      else $error("bad pointer not refused");
   a_dec_zero_flag: assert property (take && op_i == 3'h0 && src0_i == 16'h0000 && !ptr_err_i
      |=> zero_flag_o && wr0_o)
      else $error("zero result without zero flag");
   a_digit_fault: assert property (take && op_i == 3'h0 && src0_i[3:0] > 4'h9 |=> fault_flag_o)
      else $error("non decimal digit not refused");
   a_seconds_range: assert property (take && op_i == 3'h2 && src0_i[7:0] > 8'h59 |=> fault_flag_o)
      else $error("seconds above 59 not refused");
   a_ascii_zero_kept: assert property (take && op_i == 3'h4 |=> $stable(zero_flag_o))
      else $error("zero flag touched by ascii conversion");
   a_pair_write: assert property (wr1_o |-> wr0_o && done_o)
      else $error("upper word written alone");
   a_busy_ends_done: assert property ($fell(busy_o) |-> done_o)
      else $error("iteration ended without done");
endmodule // btac_convert_checker
bind btac_convert_unit btac_convert_checker i_btac_convert_checker (
   .clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .busy_o(busy_o), .done_o(done_o),
   .wr0_o(wr0_o), .wr1_o(wr1_o), .fault_flag_o(fault_flag_o), .zero_flag_o(zero_flag_o),
   .ptr_err_i(ptr_err_i), .op_i(op_i), .src0_i(src0_i), .res0_o(res0_o));

// File: tb/btac_wordmem_model.sv
`timescale 1ns/1ps
module btac_wordmem_model (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        wr0_i,
   input  wire        wr1_i,
   input  wire        load_i,
   input  wire [15:0] res0_i,
   input  wire [15:0] res1_i,
   input  wire [15:0] load_val_i,
   output reg  [15:0] word0_o,
   output reg  [15:0] word1_o
);
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         word0_o <= 16'h0000;
         word1_o <= 16'h0000;
      end else begin
         if (load_i) word0_o <= load_val_i;
         else if (wr0_i) word0_o <= res0_i;
         if (wr1_i) word1_o <= res1_i;
      end
   end
endmodule // btac_wordmem_model

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   reg         clk_i = 1'b0, rst_i = 1'b1, start_i = 1'b0, ld = 1'b0;
   reg         src_span_err_i = 1'b0, dst_span_err_i = 1'b0, ptr_err_i = 1'b0;
   reg  [2:0]  op_i = 3'h0;
   reg  [15:0] src0_i = 16'h0000, src1_i = 16'h0000, src2_i = 16'h0000, sel = 16'h0000;
   reg  [15:0] ld_val = 16'h0000;
   wire        busy_o, done_o, wr0_o, wr1_o, fault_flag_o, zero_flag_o;
   wire [15:0] res0_o, res1_o, dst0, mem1;
   wire [3:0]  flg = {fault_flag_o, zero_flag_o, wr0_o, wr1_o};
   integer     n_mismatch = 0;
   integer     checked = 0;
   reg         saw_busy = 1'b0;
   always #4 clk_i = ~clk_i;
   btac_convert_unit i_btac_convert_unit (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .op_i(op_i),
      .src0_i(src0_i), .src1_i(src1_i), .src2_i(src2_i), .position_spec_word_i(sel), .dst0_i(dst0),
      .src_span_err_i(src_span_err_i), .dst_span_err_i(dst_span_err_i), .ptr_err_i(ptr_err_i),
      .busy_o(busy_o), .done_o(done_o), .res0_o(res0_o), .res1_o(res1_o), .wr0_o(wr0_o), .wr1_o(wr1_o),
      .fault_flag_o(fault_flag_o), .zero_flag_o(zero_flag_o));
   btac_wordmem_model i_btac_wordmem_model (.clk_i(clk_i), .rst_i(rst_i), .wr0_i(wr0_o), .wr1_i(wr1_o),
      .load_i(ld), .res0_i(res0_o), .res1_i(res1_o), .load_val_i(ld_val), .word0_o(dst0), .word1_o(mem1));
   task tally_and_finish;
      begin
         $display("comparisons %0d mismatches %0d", checked, n_mismatch);
         if (n_mismatch == 0 && checked > 0) $display("All checks passed");
         else $display("Checks failed");
         $finish;
      end
   endtask
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task run(input [2:0] op, input [15:0] s0, input [15:0] s1, input [15:0] sl);
      integer i;
      begin
         @(negedge clk_i);
         op_i = op;
         src0_i = s0;
         src1_i = s1;
         sel = sl;
         start_i = 1'b1;
         @(negedge clk_i);
         start_i = 1'b0;
         saw_busy = 1'b0;
         i = 0;
         while (done_o !== 1'b1 && i < 11000) begin
            if (busy_o === 1'b1) saw_busy = 1'b1;
            @(negedge clk_i);
            i = i + 1;
         end
         if (i >= 11000) begin
            n_mismatch = n_mismatch + 1;
            tally_and_finish;
         end
      end
   endtask
   task t_dec2bin;
      begin
         run(3'h0, 16'h1234, 0, 0); chk(res0_o, 16'h04d2);
         chk(flg, 4'h2);
         run(3'h0, 16'h0000, 0, 0); chk(flg, 4'h6);
         run(3'h0, 16'h12a4, 0, 0); chk(flg, 4'hc);
         chk(res0_o, 16'h0000);
         run(3'h0, 16'h000b, 0, 0); chk(flg, 4'hc);
         $display("test dec2bin done");
      end
   endtask
   task t_bin2dec;
      begin
         run(3'h1, 16'h270f, 0, 0); chk(res0_o, 16'h9999);
         chk(flg, 4'h2);
         run(3'h1, 16'h2710, 0, 0); chk(flg, 4'h8);
         chk(res0_o, 16'h9999);
         run(3'h1, 16'h0000, 0, 0); chk(flg, 4'h6);
         $display("test bin2dec done");
      end
   endtask
   task t_dur2sec;
      begin
         run(3'h2, 16'h3207, 16'h2815, 0); chk(res0_o, 16'h5927);
         chk(res1_o, 16'h1013);
         chk(flg, 4'h3);
         run(3'h2, 16'h6000, 0, 0); chk(flg, 4'h8);
         run(3'h2, 16'h0060, 0, 0); chk(flg, 4'h8);
         src_span_err_i = 1'b1;
         run(3'h2, 16'h0000, 0, 0); chk(flg, 4'h8);
         src_span_err_i = 1'b0;
         dst_span_err_i = 1'b1;
         run(3'h2, 16'h0000, 0, 0); chk(flg, 4'h8);
         dst_span_err_i = 1'b0;
         chk(mem1, 16'h1013);
         $display("test dur2sec done");
      end
   endtask
   task t_sec2dur;
      begin
         run(3'h3, 16'h0125, 0, 0); chk(res0_o, 16'h0205);
         chk(res1_o, 16'h0000);
         chk(flg, 4'h3);
         chk(saw_busy, 1'b1);
         run(3'h3, 16'h9999, 16'h3599, 0); chk(res1_o, 16'h9999);
         chk(res0_o, 16'h5959);
         run(3'h3, 16'h0000, 16'h3600, 0); chk(flg, 4'h8);
         run(3'h3, 16'h0000, 16'h9999, 0); chk(flg, 4'h8);
         run(3'h3, 16'h00a0, 0, 0); chk(flg, 4'h8);
         run(3'h3, 16'h0000, 0, 0); chk(flg, 4'h7);
         ptr_err_i = 1'b1;
         run(3'h3, 16'h0001, 0, 0); chk(flg, 4'hc);
         chk(saw_busy, 1'b0);
         ptr_err_i = 1'b0;
         $display("test sec2dur done");
      end
   endtask
   task t_asc2nib;
      integer k;
      begin
         @(negedge clk_i);
         ld_val = 16'h5555;
         ld = 1'b1;
         @(negedge clk_i);
         ld = 1'b0;
         for (k = 0; k < 4; k = k + 1) begin
            @(negedge clk_i); chk(done_o, 1'b0);
            chk(dst0, 16'h5555);
         end
         run(3'h4, 16'h4131, 0, 16'h0013); chk(res0_o, 16'h155a);
         chk(flg, 4'h6);
         src2_i = 16'h0046;
         run(3'h4, 16'h4300, 16'h4544, 16'h0130); chk(res0_o, 16'hfedc);
         run(3'h4, 16'h00b1, 0, 16'h1000); chk(res0_o, 16'hfed1);
         run(3'h4, 16'h00b1, 0, 16'h2000); chk(flg, 4'hc);
         run(3'h4, 16'h0047, 0, 16'h0000); chk(flg, 4'hc);
         chk(res0_o, 16'hfed1);
         run(3'h4, 16'h0031, 0, 16'h3000); chk(flg, 4'hc);
         $display("test asc2nib done");
      end
   endtask
   initial begin
      repeat (12) @(posedge clk_i);
      @(negedge clk_i);
      rst_i = 1'b0;
      t_dec2bin;
      t_bin2dec;
      t_dur2sec;
      t_sec2dur;
      t_asc2nib;
      tally_and_finish;
   end
endmodule // tb_top
